// ---- design/zch_pkg.sv ----
// Purpose: shared constants and types for the zero/cal command handler
// Assumes: commands arrive already parsed as opcode, argument, channel suffix
// Notes:   error codes are carried as signed 10-bit values
package zch_pkg;

  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_CAL_ALL  = 4'h1,
    OP_CAL_AUTO = 4'h2,
    OP_ZERO     = 4'h3,
    OP_ZERO_NRM = 4'h4,
    OP_EXT_SET  = 4'h5,
    OP_EXT_Q    = 4'h6,
    OP_LOCK_SET = 4'h7,
    OP_LOCK_Q   = 4'h8,
    OP_RCF_SET  = 4'h9,
    OP_RCF_Q    = 4'hA,
    OP_CAL_Q    = 4'hB,
    OP_ZERO_Q   = 4'hC,
    OP_MEAS_Q   = 4'hD,
    OP_TABLE    = 4'hE
  } zch_op_e;

  typedef enum logic [2:0] {
    ARG_OFF   = 3'h0,
    ARG_ON    = 3'h1,
    ARG_ONCE  = 3'h2,
    ARG_VALUE = 3'h3,
    ARG_DEF   = 3'h4,
    ARG_MIN   = 3'h5,
    ARG_MAX   = 3'h6
  } zch_arg_e;

  typedef enum logic [1:0] {
    JOB_ZERO  = 2'h0,
    JOB_CAL   = 2'h1,
    JOB_ZNORM = 2'h2
  } zch_job_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_WAIT = 2'h2
  } zch_state_e;

  // error codes, two's complement
  localparam logic [9:0] ERR_SETTINGS = 10'h323; // -221
  localparam logic [9:0] ERR_ILLEGAL  = 10'h320; // -224
  localparam logic [9:0] ERR_STALE    = 10'h31A; // -230
  localparam logic [9:0] ERR_QUEST    = 10'h319; // -231
  localparam logic [9:0] ERR_HWMISS   = 10'h30F; // -241

  // message selector sent with an error
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_CAL  = 2'h1;
  localparam logic [1:0] MSG_ZERO = 2'h2;

  // factor in tenths of a percent
  localparam logic [10:0] RCF_MIN = 11'h00A; // 1.0 %
  localparam logic [10:0] RCF_MAX = 11'h5DC; // 150.0 %
  localparam logic [10:0] RCF_DEF = 11'h3E8; // 100.0 %

  localparam logic [1:0] CH_A = 2'h1;
  localparam logic [1:0] CH_B = 2'h2;

endpackage : zch_pkg

// ---- design/zch_handler.sv ----
// Purpose: zero/cal command handler for a two-channel meter
// Assumes: one parsed command per cmdValid pulse, sensor side answers done pulses
// Notes:   jobs are queued per channel and run overlapped with later commands
// Notes on behaviour
// R1 - calibrate once calibrates channel; off ignored; on gives -224
// R2 - host puts sensor on 1 mW reference before calibrating
// R3 - failed calibration queues -231 with cal text naming channel
// R4 - zero or cal with no sensor queues -241 and is not run
// R5 - reference factor in use is whichever source was written last
// R6 - one-shot queries answer 0; auto calibration inactive after reset
// R7 - host should zero before calibrating; not enforced
// R8 - one external trigger enable shared by both channel suffixes
// R9 - trigger enable off after reset; query answers 1 or 0
// R10 - lockout with unzeroed or uncalibrated sensor blocks results, queues -230
// R11 - zeroed and calibrated sensor returns results despite lockout
// R12 - lockout per channel survives reset; query answers 1 or 0
// R13 - manual factor 1.0 to 150.0 percent; def 100, min, max keywords
// R14 - reset sets factor to 100 percent; query gives value or limits
// R15 - writing factor with table-holding sensor queues -241
// R16 - zero once runs zeroing; off ignored; on gives -224
// R17 - host keeps power off sensor while zeroing
// R18 - failed zeroing queues -231 with zero text naming channel
// R19 - normal-path zero touches only normal path of dual-path sensor
// R20 - normal-path zero: -241 if absent or incompatible, -221 if not normal
// R21 - suffix 1 or none selects channel A, suffix 2 channel B
// R22 - calibrate and zero run overlapped; parsing continues meanwhile
// R23 - errors queued in order of occurrence
`timescale 1ns/1ps
`default_nettype none

module zch_handler
  import zch_pkg::*;
#(
  parameter int unsigned NCH = 2
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            cmdValid,
  input  wire logic [3:0]      cmdOp,
  input  wire logic [2:0]      cmdArg,
  input  wire logic [1:0]      cmdSuffix,
  input  wire logic [10:0]     cmdValue,
  input  wire logic [NCH-1:0]  sensorPresent,
  input  wire logic [NCH-1:0]  sensorHasTable,
  input  wire logic [NCH-1:0]  sensorDualPath,
  input  wire logic [NCH-1:0]  sensorNormalMode,
  input  wire logic [NCH-1:0]  sensorChanged,
  input  wire logic [NCH-1:0]  tableFactorValid,
  input  wire logic [10:0]     tableFactor,
  input  wire logic [NCH-1:0]  jobDone,
  input  wire logic [NCH-1:0]  jobFail,
  input  wire logic            errReady,
  output logic [NCH-1:0]       jobStart,
  output logic [1:0]           jobKind,
  output logic [10:0]          refCalFactor0,
  output logic [10:0]          refCalFactor1,
  output logic                 extTriggerEnable,
  output logic [NCH-1:0]       zeroCalLockout,
  output logic                 measAllow,
  output logic                 rspValid,
  output logic [10:0]          rspData,
  output logic                 errValid,
  output logic [9:0]           errCode,
  output logic [1:0]           errMsg,
  output logic                 errChan
);

  // channel index from suffix
  function automatic logic chanOf(input logic [1:0] sfx);
    chanOf = (sfx == CH_B); // [R21]
  endfunction

  // clamp a factor into the legal range
  function automatic logic [10:0] clampRcf(input logic [10:0] v);
    if (v < RCF_MIN) clampRcf = RCF_MIN;
    else if (v > RCF_MAX) clampRcf = RCF_MAX;
    else clampRcf = v;
  endfunction

  logic [10:0]    rcf_r     [NCH];
  logic [10:0]    rcf_nxt   [NCH];
  logic [NCH-1:0] zeroed_r, zeroed_nxt, caled_r, caled_nxt;
  logic [NCH-1:0] lock_r, lock_nxt;
  logic           ext_r, ext_nxt;
  logic [NCH-1:0] pendZ_r, pendZ_nxt, pendC_r, pendC_nxt, pendN_r, pendN_nxt;
  zch_state_e     st_r      [NCH];
  zch_state_e     st_nxt    [NCH];
  zch_job_e       job_r     [NCH];
  zch_job_e       job_nxt   [NCH];
  logic           rspV_r, rspV_nxt;
  logic [10:0]    rspD_r, rspD_nxt;
  logic           measOk_r, measOk_nxt;
  // small in-order error queue
  logic [12:0]    eq_r      [4];
  logic [12:0]    eq_nxt    [4];
  logic [2:0]     eqCnt_r, eqCnt_nxt;
  logic           ch;
  logic [NCH-1:0] start;
  logic [1:0]     kindSel;

  assign ch = chanOf(cmdSuffix);

  always_comb begin
    logic [12:0] cmdErr;
    logic        cmdErrV;
    logic [12:0]    jobErr [NCH];
    logic [NCH-1:0] jobErrV;
    logic [2:0]     cnt;
    cmdErr     = '0;
    cmdErrV    = 1'b0;
    jobErr     = '{default: '0};
    jobErrV    = '0;
    rcf_nxt    = rcf_r;
    zeroed_nxt = zeroed_r;
    caled_nxt  = caled_r;
    lock_nxt   = lock_r;
    ext_nxt    = ext_r;
    pendZ_nxt  = pendZ_r;
    pendC_nxt  = pendC_r;
    pendN_nxt  = pendN_r;
    st_nxt     = st_r;
    job_nxt    = job_r;
    rspV_nxt   = 1'b0;
    rspD_nxt   = rspD_r;
    measOk_nxt = measOk_r;
    eq_nxt     = eq_r;
    cnt        = eqCnt_r;
    start      = '0;
    kindSel    = JOB_ZERO;
    // new sensor must be zeroed and calibrated again
    for (int i = 0; i < NCH; i++) begin
      if (sensorChanged[i]) begin
        zeroed_nxt[i] = 1'b0;
        caled_nxt[i]  = 1'b0;
      end
      if (tableFactorValid[i]) begin
        rcf_nxt[i] = clampRcf(tableFactor); // [R5]
      end
    end
    if (cmdValid) begin
      unique case (zch_op_e'(cmdOp))
        OP_CAL_ALL, OP_CAL_AUTO, OP_ZERO, OP_ZERO_NRM: begin
          if (cmdArg == ARG_ON) begin
            cmdErr  = {ERR_ILLEGAL, MSG_NONE, ch}; // [R1] [R16]
            cmdErrV = 1'b1;
          end else if (cmdArg == ARG_ONCE) begin
            if (!sensorPresent[ch]) begin
              cmdErr  = {ERR_HWMISS, MSG_NONE, ch}; // [R4] [R20]
              cmdErrV = 1'b1;
            end else if (zch_op_e'(cmdOp) == OP_ZERO_NRM && !sensorDualPath[ch]) begin
              cmdErr  = {ERR_HWMISS, MSG_NONE, ch}; // [R20]
              cmdErrV = 1'b1;
            end else if (zch_op_e'(cmdOp) == OP_ZERO_NRM && !sensorNormalMode[ch]) begin
              cmdErr  = {ERR_SETTINGS, MSG_NONE, ch}; // [R20]
              cmdErrV = 1'b1;
            end else begin
              // queue job, later commands keep flowing [R22]
              if (zch_op_e'(cmdOp) == OP_ZERO_NRM) pendN_nxt[ch] = 1'b1; // [R19]
              if (zch_op_e'(cmdOp) == OP_ZERO || zch_op_e'(cmdOp) == OP_CAL_ALL) pendZ_nxt[ch] = 1'b1; // [R16]
              if (zch_op_e'(cmdOp) == OP_CAL_AUTO || zch_op_e'(cmdOp) == OP_CAL_ALL) pendC_nxt[ch] = 1'b1; // [R1]
            end
          end
        end
        OP_CAL_Q, OP_ZERO_Q: begin
          rspV_nxt = 1'b1;
          rspD_nxt = '0; // [R6]
        end
        OP_EXT_SET: ext_nxt = (cmdArg == ARG_ON); // [R8]
        OP_EXT_Q: begin
          rspV_nxt = 1'b1;
          rspD_nxt = {10'h000, ext_r}; // [R9]
        end
        OP_LOCK_SET: lock_nxt[ch] = (cmdArg == ARG_ON);
        OP_LOCK_Q: begin
          rspV_nxt = 1'b1;
          rspD_nxt = {10'h000, lock_r[ch]}; // [R12]
        end
        OP_RCF_SET: begin
          if (sensorHasTable[ch]) begin
            cmdErr  = {ERR_HWMISS, MSG_NONE, ch}; // [R15]
            cmdErrV = 1'b1;
          end else if (cmdArg == ARG_MIN) rcf_nxt[ch] = RCF_MIN; // [R13]
          else if (cmdArg == ARG_MAX) rcf_nxt[ch] = RCF_MAX;
          else if (cmdArg == ARG_DEF) rcf_nxt[ch] = RCF_DEF;
          else rcf_nxt[ch] = clampRcf(cmdValue); // [R5] [R13]
        end
        OP_RCF_Q: begin
          rspV_nxt = 1'b1;
          if (cmdArg == ARG_MIN) rspD_nxt = RCF_MIN; // [R14]
          else if (cmdArg == ARG_MAX) rspD_nxt = RCF_MAX;
          else rspD_nxt = rcf_r[ch];
        end
        OP_MEAS_Q: begin
          if (lock_r[ch] && !(zeroed_r[ch] && caled_r[ch])) begin
            measOk_nxt = 1'b0; // [R10]
            cmdErr     = {ERR_STALE, MSG_NONE, ch};
            cmdErrV    = 1'b1;
          end else begin
            measOk_nxt = 1'b1; // [R11]
          end
        end
        default: ;
      endcase
    end
    // per-channel job runner, zero before cal
    for (int i = 0; i < NCH; i++) begin
      case (st_r[i])
        ST_IDLE: begin
          if (start == '0 && (pendN_r[i] || pendZ_r[i] || pendC_r[i])) begin
            start[i]  = 1'b1;
            st_nxt[i] = ST_WAIT;
            if (pendN_r[i]) begin
              job_nxt[i]   = JOB_ZNORM;
              pendN_nxt[i] = 1'b0;
            end else if (pendZ_r[i]) begin
              job_nxt[i]   = JOB_ZERO;
              pendZ_nxt[i] = 1'b0;
            end else begin
              job_nxt[i]   = JOB_CAL;
              pendC_nxt[i] = 1'b0;
            end
            kindSel = job_nxt[i];
          end
        end
        ST_WAIT: begin
          if (jobDone[i]) begin
            st_nxt[i] = ST_IDLE;
            // done is a pulse, so the failure is queued at once
            if (jobFail[i]) begin
              jobErr[i]  = {ERR_QUEST, (job_r[i] == JOB_CAL) ? MSG_CAL : MSG_ZERO, i[0]}; // [R3] [R18]
              jobErrV[i] = 1'b1;
            end else if (job_r[i] == JOB_CAL) begin
              caled_nxt[i] = 1'b1;
            end else if (job_r[i] == JOB_ZERO) begin
              zeroed_nxt[i] = 1'b1;
            end
            if (jobFail[i] && job_r[i] == JOB_CAL) caled_nxt[i] = 1'b0;
            else if (jobFail[i]) zeroed_nxt[i] = 1'b0;
          end
        end
        default: st_nxt[i] = ST_IDLE;
      endcase
    end
    // error queue: pop, then push in order [R23]
    if (errReady && cnt != 3'h0) begin
      for (int k = 0; k < 3; k++) eq_nxt[k] = eq_nxt[k+1];
      cnt = cnt - 3'h1;
    end
    if (cmdErrV && cnt != 3'h4) begin
      eq_nxt[cnt[1:0]] = cmdErr; // [R23]
      cnt = cnt + 3'h1;
    end
    for (int i = 0; i < NCH; i++) begin
      if (jobErrV[i] && cnt != 3'h4) begin
        eq_nxt[cnt[1:0]] = jobErr[i]; // [R23]
        cnt = cnt + 3'h1;
      end
    end
    eqCnt_nxt = cnt;
  end

  always_ff @(posedge clk) begin
    lock_r <= lock_nxt; // lockout kept through reset [R12]
    zeroed_r <= zeroed_nxt;
    caled_r  <= caled_nxt;
    rspD_r   <= rspD_nxt;
    if (srst) begin
      for (int i = 0; i < NCH; i++) begin
        rcf_r[i] <= RCF_DEF; // [R14]
        st_r[i]  <= ST_IDLE; // [R6]
        job_r[i] <= JOB_ZERO;
      end
      for (int k = 0; k < 4; k++) eq_r[k] <= '0;
      ext_r    <= 1'b0; // [R9]
      pendZ_r  <= '0;
      pendC_r  <= '0;
      pendN_r  <= '0;
      rspV_r   <= 1'b0;
      measOk_r <= 1'b0;
      eqCnt_r  <= '0;
    end else begin
      rcf_r    <= rcf_nxt;
      st_r     <= st_nxt;
      job_r    <= job_nxt;
      eq_r     <= eq_nxt;
      ext_r    <= ext_nxt;
      pendZ_r  <= pendZ_nxt;
      pendC_r  <= pendC_nxt;
      pendN_r  <= pendN_nxt;
      rspV_r   <= rspV_nxt;
      measOk_r <= measOk_nxt;
      eqCnt_r  <= eqCnt_nxt;
    end
  end

  assign jobStart         = start;
  assign jobKind          = kindSel;
  assign refCalFactor0    = rcf_r[0];
  assign refCalFactor1    = rcf_r[NCH-1];
  assign extTriggerEnable = ext_r;
  assign zeroCalLockout   = lock_r;
  assign measAllow        = measOk_r;
  assign rspValid         = rspV_r;
  assign rspData          = rspD_r;
  assign errValid         = (eqCnt_r != 3'h0);
  assign errCode          = eq_r[0][12:3];
  assign errMsg           = eq_r[0][2:1];
  assign errChan          = eq_r[0][0];

endmodule // zch_handler

`default_nettype wire

// ---- test/zch_handler_sva.sv ----
// Purpose: port assertions for zch_handler
// Assumes: error antecedents fire only with the queue empty
// Notes:   bound to every zch_handler instance
`timescale 1ns/1ps
`default_nettype none
module zch_handler_sva
  import zch_pkg::*;
#(parameter int unsigned NCH = 2) (
  input wire logic            clk,
  input wire logic            srst,
  input wire logic            cmdValid,
  input wire logic [3:0]      cmdOp,
  input wire logic [2:0]      cmdArg,
  input wire logic [1:0]      cmdSuffix,
  input wire logic [NCH-1:0]  sensorPresent,
  input wire logic [NCH-1:0]  sensorHasTable,
  input wire logic [NCH-1:0]  sensorDualPath,
  input wire logic [NCH-1:0]  sensorNormalMode,
  input wire logic [NCH-1:0]  jobStart,
  input wire logic [1:0]      jobKind,
  input wire logic [10:0]     refCalFactor0,
  input wire logic [10:0]     refCalFactor1,
  input wire logic            extTriggerEnable,
  input wire logic            rspValid,
  input wire logic [10:0]     rspData,
  input wire logic            errValid,
  input wire logic [9:0]      errCode
);
  logic chB;
  logic cmdOnce;
  assign chB     = cmdSuffix == CH_B;
  assign cmdOnce = cmdValid && cmdArg == ARG_ONCE;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rsp; cmdValid && cmdOp inside {OP_EXT_Q, OP_LOCK_Q, OP_RCF_Q, OP_CAL_Q, OP_ZERO_Q} |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("query got no answer");
  property p_once; cmdValid && cmdOp inside {OP_CAL_Q, OP_ZERO_Q} |=> rspValid && rspData == 11'h000; endproperty
  a_once: assert property (p_once) else $error("one-shot query not zero");
  property p_extq; cmdValid && cmdOp == OP_EXT_Q |=> rspData == {10'h000, extTriggerEnable}; endproperty
  a_extq: assert property (p_extq) else $error("trigger query wrong");
  property p_ext; cmdValid && cmdOp == OP_EXT_SET && cmdArg == ARG_ON |=> extTriggerEnable; endproperty
  a_ext: assert property (p_ext) else $error("trigger enable not set");
  property p_ill; cmdValid && cmdOp == OP_CAL_AUTO && cmdArg == ARG_ON && !errValid |=> errValid && errCode == ERR_ILLEGAL; endproperty
  a_ill: assert property (p_ill) else $error("calibrate on not refused");
  property p_nos; cmdOnce && cmdOp == OP_CAL_AUTO && !sensorPresent[chB] && !errValid
    |=> errValid && errCode == ERR_HWMISS && !jobStart[$past(chB)]; endproperty
  a_nos: assert property (p_nos) else $error("absent sensor not refused");
  property p_nrm; cmdOnce && cmdOp == OP_ZERO_NRM && jobStart == '0 && sensorPresent[chB] && sensorDualPath[chB]
    && sensorNormalMode[chB] |=> jobStart[$past(chB)] && jobKind == JOB_ZNORM; endproperty
  a_nrm: assert property (p_nrm) else $error("normal-path zero not started");
  property p_rcf; cmdValid && cmdOp == OP_RCF_SET && cmdArg == ARG_MAX && chB && !sensorHasTable[1]
    |=> refCalFactor1 == RCF_MAX; endproperty
  a_rcf: assert property (p_rcf) else $error("factor max not applied");
  property p_rst; $fell(srst) |-> refCalFactor0 == RCF_DEF && refCalFactor1 == RCF_DEF && !extTriggerEnable; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule // zch_handler_sva
bind zch_handler zch_handler_sva #(.NCH(NCH)) zch_handler_sva_i (.clk(clk), .srst(srst), .cmdValid(cmdValid),
  .cmdOp(cmdOp), .cmdArg(cmdArg), .cmdSuffix(cmdSuffix), .sensorPresent(sensorPresent),
  .sensorHasTable(sensorHasTable), .sensorDualPath(sensorDualPath), .sensorNormalMode(sensorNormalMode),
  .jobStart(jobStart), .jobKind(jobKind), .refCalFactor0(refCalFactor0), .refCalFactor1(refCalFactor1),
  .extTriggerEnable(extTriggerEnable), .rspValid(rspValid), .rspData(rspData), .errValid(errValid),
  .errCode(errCode));
`default_nettype wire

// ---- test/zch_sensor_model.sv ----
// Purpose: sensor-side job responder
// Assumes: one job per channel at a time
// Notes:   lat sets job length, failReq sets outcome
`timescale 1ns/1ps
`default_nettype none
module zch_sensor_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] jobStart,
  input  wire logic [1:0] failReq,
  input  wire logic [3:0] lat,
  output logic      [1:0] jobDone,
  output logic      [1:0] jobFail
);
  // sensor on reference for cal, unpowered for zero
  logic [3:0] cnt_r [2];
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (srst) cnt_r[c] <= 4'h0;
      else if (jobStart[c]) cnt_r[c] <= lat + 4'h1;
      else if (cnt_r[c] != 4'h0) cnt_r[c] <= cnt_r[c] - 4'h1;
    end
  end
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      jobDone[c] = cnt_r[c] == 4'h1;
      // outcome valid only with done
      jobFail[c] = jobDone[c] ? failReq[c] : ~failReq[c];
    end
  end
endmodule // zch_sensor_model
`default_nettype wire

// ---- test/test_zch_handler.sv ----
// Purpose: scenario bench for zch_handler
// Assumes: sensor model answers jobs
// Notes:   lockout written before use
`timescale 1ns/1ps
`default_nettype none
module test_zch_handler
  import zch_pkg::*;
;
  logic        clk, srst, cmdValid, errReady, extTriggerEnable, measAllow, rspValid, errValid, errChan;
  logic [3:0]  cmdOp, lat;
  logic [2:0]  cmdArg;
  logic [1:0]  cmdSuffix, jobStart, jobKind, errMsg, sensorPresent, sensorHasTable, sensorDualPath;
  logic [1:0]  sensorNormalMode, sensorChanged, tableFactorValid, jobDone, jobFail, failReq, zeroCalLockout;
  logic [10:0] cmdValue, tableFactor, refCalFactor0, refCalFactor1, rspData;
  logic [9:0]  errCode;
  int          errTotal, totalChecks;
  zch_handler #(.NCH(2)) zch_handler_i (.clk(clk), .srst(srst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdArg(cmdArg), .cmdSuffix(cmdSuffix), .cmdValue(cmdValue), .sensorPresent(sensorPresent),
    .sensorHasTable(sensorHasTable), .sensorDualPath(sensorDualPath), .sensorNormalMode(sensorNormalMode),
    .sensorChanged(sensorChanged), .tableFactorValid(tableFactorValid), .tableFactor(tableFactor),
    .jobDone(jobDone), .jobFail(jobFail), .errReady(errReady), .jobStart(jobStart), .jobKind(jobKind),
    .refCalFactor0(refCalFactor0), .refCalFactor1(refCalFactor1), .extTriggerEnable(extTriggerEnable),
    .zeroCalLockout(zeroCalLockout), .measAllow(measAllow), .rspValid(rspValid), .rspData(rspData),
    .errValid(errValid), .errCode(errCode), .errMsg(errMsg), .errChan(errChan));
  zch_sensor_model zch_sensor_model_i (.clk(clk), .srst(srst), .jobStart(jobStart), .failReq(failReq),
    .lat(lat), .jobDone(jobDone), .jobFail(jobFail));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task giveVerdict;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [10:0] seen, input logic [10:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cmd(input logic [3:0] op, input logic [2:0] arg, input logic [1:0] sfx, input logic [10:0] val);
    @(posedge clk) {cmdValid, cmdOp, cmdArg, cmdSuffix, cmdValue} <= {1'b1, op, arg, sfx, val};
    @(posedge clk) cmdValid <= 1'b0;
    #1;
  endtask
  task get_err(input logic [9:0] c, input logic [1:0] m, input logic ch);
    int n;
    n = 0;
    while (errValid !== 1'b1 && n < 50) begin
      @(posedge clk); #1; n++;
    end
    chk({errValid, errCode}, {1'b1, c});
    chk({9'h000, errMsg}, {9'h000, m});
    if (m != MSG_NONE) chk({10'h000, errChan}, {10'h000, ch});
    @(posedge clk) errReady <= 1'b1;
    @(posedge clk) errReady <= 1'b0;
    #1;
  endtask
  task wait_done(input int c);
    int n;
    n = 0;
    while (jobDone[c] !== 1'b1 && n < 50) begin
      @(posedge clk); #1; n++;
    end
    chk({10'h000, jobDone[c]}, 11'h001);
    @(posedge clk); #1;
  endtask
  task t_ext;
    cmd(OP_EXT_SET, ARG_ON, 2'h2, 11'h000);
    cmd(OP_EXT_Q, ARG_OFF, 2'h1, 11'h000); chk({rspValid, rspData[9:0]}, 11'h401);
    cmd(OP_EXT_SET, ARG_OFF, 2'h1, 11'h000); chk({10'h000, extTriggerEnable}, 11'h000);
  endtask
  task t_once;
    cmd(OP_CAL_AUTO, ARG_OFF, 2'h1, 11'h000); chk({8'h00, errValid, jobStart}, 11'h000);
    cmd(OP_ZERO, ARG_OFF, 2'h2, 11'h000); chk({8'h00, errValid, jobStart}, 11'h000);
    cmd(OP_CAL_Q, ARG_OFF, 2'h1, 11'h000); chk(rspData, 11'h000);
    cmd(OP_ZERO_Q, ARG_OFF, 2'h2, 11'h000); chk(rspData, 11'h000);
    @(posedge clk) sensorPresent <= 2'b01;
    cmd(OP_ZERO, ARG_ON, 2'h2, 11'h000);
    cmd(OP_ZERO_NRM, ARG_ONCE, 2'h2, 11'h000);
    get_err(ERR_ILLEGAL, MSG_NONE, 1'b0);
    get_err(ERR_HWMISS, MSG_NONE, 1'b0);
    cmd(OP_CAL_AUTO, ARG_ON, 2'h1, 11'h000); get_err(ERR_ILLEGAL, MSG_NONE, 1'b0);
    cmd(OP_CAL_AUTO, ARG_ONCE, 2'h2, 11'h000); chk({9'h000, jobStart}, 11'h000);
    get_err(ERR_HWMISS, MSG_NONE, 1'b0);
    @(posedge clk) sensorPresent <= 2'b11;
  endtask
  task t_rcf;
    cmd(OP_RCF_SET, ARG_VALUE, 2'h1, 11'h3D4); chk(refCalFactor0, 11'h3D4);
    cmd(OP_RCF_SET, ARG_MIN, 2'h2, 11'h000); chk(refCalFactor1, RCF_MIN);
    cmd(OP_RCF_SET, ARG_MAX, 2'h2, 11'h000); chk(refCalFactor1, RCF_MAX);
    cmd(OP_RCF_Q, ARG_MIN, 2'h2, 11'h000); chk(rspData, RCF_MIN);
    cmd(OP_RCF_SET, ARG_DEF, 2'h2, 11'h000); chk(refCalFactor1, RCF_DEF);
    @(posedge clk) {tableFactorValid, tableFactor} <= {2'b01, 11'h300};
    @(posedge clk) tableFactorValid <= 2'b00;
    #1 chk(refCalFactor0, 11'h300);
    cmd(OP_RCF_SET, ARG_VALUE, 2'h0, 11'h3D4); chk(refCalFactor0, 11'h3D4);
    @(posedge clk) sensorHasTable <= 2'b01;
    cmd(OP_RCF_SET, ARG_VALUE, 2'h1, 11'h100); get_err(ERR_HWMISS, MSG_NONE, 1'b0);
    chk(refCalFactor0, 11'h3D4);
    cmd(OP_RCF_Q, ARG_OFF, 2'h1, 11'h000); chk(rspData, 11'h3D4);
  endtask
  task t_fail;
    @(posedge clk) failReq <= 2'b11;
    cmd(OP_CAL_AUTO, ARG_ONCE, 2'h2, 11'h000); chk({7'h00, jobStart, jobKind}, {7'h00, 2'b10, JOB_CAL});
    get_err(ERR_QUEST, MSG_CAL, 1'b1);
    cmd(OP_ZERO, ARG_ONCE, 2'h0, 11'h000); chk({7'h00, jobStart, jobKind}, {7'h00, 2'b01, JOB_ZERO});
    get_err(ERR_QUEST, MSG_ZERO, 1'b0);
    @(posedge clk) {failReq, sensorDualPath, sensorNormalMode} <= 6'h00;
    cmd(OP_ZERO_NRM, ARG_ONCE, 2'h2, 11'h000); get_err(ERR_HWMISS, MSG_NONE, 1'b0);
    @(posedge clk) sensorDualPath <= 2'b10;
    cmd(OP_ZERO_NRM, ARG_ONCE, 2'h2, 11'h000); get_err(ERR_SETTINGS, MSG_NONE, 1'b0);
    @(posedge clk) sensorNormalMode <= 2'b10;
    cmd(OP_ZERO_NRM, ARG_ONCE, 2'h2, 11'h000); chk({7'h00, jobStart, jobKind}, {7'h00, 2'b10, JOB_ZNORM});
    wait_done(1);
  endtask
  task t_lock;
    @(posedge clk) lat <= 4'h9;
    cmd(OP_LOCK_SET, ARG_ON, 2'h1, 11'h000);
    cmd(OP_LOCK_Q, ARG_OFF, 2'h0, 11'h000); chk({rspData[8:0], zeroCalLockout}, 11'h005);
    cmd(OP_MEAS_Q, ARG_OFF, 2'h2, 11'h000); chk({9'h000, measAllow, errValid}, 11'h002);
    cmd(OP_MEAS_Q, ARG_OFF, 2'h1, 11'h000); chk({10'h000, measAllow}, 11'h000);
    get_err(ERR_STALE, MSG_NONE, 1'b0);
    cmd(OP_CAL_ALL, ARG_ONCE, 2'h1, 11'h000);
    wait_done(0);
    wait_done(0);
    cmd(OP_MEAS_Q, ARG_OFF, 2'h1, 11'h000); chk({9'h000, measAllow, errValid}, 11'h002);
    @(posedge clk) sensorChanged <= 2'b01;
    @(posedge clk) sensorChanged <= 2'b00;
    cmd(OP_MEAS_Q, ARG_OFF, 2'h1, 11'h000); chk({10'h000, measAllow}, 11'h000);
    get_err(ERR_STALE, MSG_NONE, 1'b0);
    cmd(OP_EXT_SET, ARG_ON, 2'h1, 11'h000);
    @(posedge clk) srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1 chk({9'h000, extTriggerEnable, rspValid}, 11'h000);
    chk(refCalFactor0, RCF_DEF);
    cmd(OP_LOCK_Q, ARG_OFF, 2'h1, 11'h000); chk(rspData, 11'h001);
  endtask
  initial begin
    {srst, cmdValid, errReady, cmdOp, cmdArg, cmdSuffix, cmdValue, tableFactor} = 34'h200000000;
    {sensorPresent, sensorHasTable, sensorDualPath, sensorNormalMode} = 8'hC0;
    {sensorChanged, tableFactorValid, failReq, lat} = 10'h003;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    cmd(OP_LOCK_SET, ARG_OFF, 2'h1, 11'h000);
    cmd(OP_LOCK_SET, ARG_OFF, 2'h2, 11'h000);
    @(posedge clk) sensorChanged <= 2'b11;
    @(posedge clk) sensorChanged <= 2'b00;
    t_ext;
    t_once;
    t_rcf;
    t_fail;
    t_lock;
    giveVerdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    giveVerdict;
  end
endmodule // test_zch_handler
`default_nettype wire
